// [inc/dma_progress_pkg.sv]
/*
 File: constants for the DMA channel progress and interrupt-enable block.
 Assumes: included before the interface and design modules.
*/
package dma_progress_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] control_offset = 8'h00;
   localparam logic [7:0] dest_addr_offset = 8'h18;
   localparam logic [7:0] remain_count_offset = 8'h1c;
   localparam logic [7:0] irq_enable_offset = 8'h20;
   localparam logic [7:0] irq_status_offset = 8'h24;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int soft_reset_bit = 1;
   localparam int start_bit = 0;
   localparam int block_done_bit = 1;
   localparam int bus_abort_bit = 0;
   localparam int count_width = 16;
   localparam logic [1:0] irq_enable_reset = 2'h1;
   localparam logic [31:0] dest_addr_reset = 32'h0000_0000;
   localparam logic [15:0] remain_count_reset = 16'h0000;
   // Bytes moved per beat (word transfers)
   localparam logic [15:0] beat_bytes = 16'h0004;
   localparam logic [31:0] beat_addr_step = 32'h0000_0004;

   // Engine states
   typedef enum logic [1:0] {st_idle, st_run} engine_state_t;
endpackage

// [inc/beat_if.sv]
/*
 File: interface carrying beat results from the engine to the register file.
 Assumes: one clock domain; both ends in the same module tree.
*/
`timescale 1ns/1ps
`default_nettype none
interface beat_if;
   logic beat;
   logic [31:0] dest_addr;
   logic [15:0] remain;
   logic done;
   logic abort;
   modport engine (output beat, dest_addr, remain, done, abort);
   modport regs (input beat, dest_addr, remain, done, abort);
endinterface
`default_nettype wire

// [design/dma_engine_core.sv]
/*
 File: channel transfer engine, counting destination address and remaining bytes.
 Assumes: bus beat completion and error are single-cycle pulses from the system bus master.
*/
`timescale 1ns/1ps
`default_nettype none
module dma_engine_core
   import dma_progress_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic soft_reset,
   input wire logic [31:0] start_dest,
   input wire logic [15:0] start_count,
   input wire logic bus_beat_done,
   input wire logic bus_error,
   output logic busy,
   beat_if.engine bi
);
   engine_state_t state_q, state_d;
   logic [31:0] addr_q, addr_d;
   logic [15:0] count_q, count_d;
   logic done_d, abort_d, beat_d, first_d;
   logic done_q, abort_q, beat_q, first_q;

   // --------------------------------------------------------------
   // Next-state logic
   // --------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      count_d = count_q;
      done_d = 1'b0;
      abort_d = 1'b0;
      beat_d = 1'b0;
      first_d = first_q;
      if (soft_reset) begin
         state_d = st_idle;
         count_d = remain_count_reset;
      end else begin
         unique case (state_q)
            st_idle: begin
               if (start && start_count != 16'h0000) begin
                  state_d = st_run;
                  addr_d = start_dest;
                  count_d = start_count;
                  first_d = 1'b1;
               end
            end
            st_run: begin
               if (bus_error) begin
                  abort_d = 1'b1;
                  state_d = st_idle;
               end else if (bus_beat_done) begin
                  beat_d = 1'b1;
                  count_d = (count_q > beat_bytes) ? count_q - beat_bytes : 16'h0000;
                  // Address of the beat just finished: start address, then one step per beat
                  first_d = 1'b0;
                  if (!first_q) begin
                     addr_d = addr_q + beat_addr_step;
                  end
                  if (count_q <= beat_bytes) begin
                     done_d = 1'b1;
                     state_d = st_idle;
                  end
               end
            end
         endcase
      end
   end

   // Register the engine state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= st_idle;
         addr_q <= dest_addr_reset;
         count_q <= remain_count_reset;
         done_q <= 1'b0;
         abort_q <= 1'b0;
         beat_q <= 1'b0;
         first_q <= 1'b0;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         count_q <= count_d;
         done_q <= done_d;
         abort_q <= abort_d;
         beat_q <= beat_d;
         first_q <= first_d;
      end
   end

   assign busy = (state_q == st_run);
   assign bi.beat = beat_q;
   assign bi.dest_addr = addr_q;
   assign bi.remain = count_q;
   assign bi.done = done_q;
   assign bi.abort = abort_q;
endmodule
`default_nettype wire

// [design/irq_status_core.sv]
/*
 File: sticky interrupt flags with write-one-to-clear and enable gating.
 Assumes: events and clear strobes are single-cycle and synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_status_core
   import dma_progress_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [1:0] events,
   input wire logic [1:0] clear,
   input wire logic [1:0] enable,
   output logic [1:0] flags,
   output logic irq_pending
);
   logic [1:0] flags_q, flags_d;

   // Set wins over a clear in the same cycle
   always_comb begin
      flags_d = (flags_q & ~clear) | events;
   end

   // Register the flags
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags_q <= 2'h0;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;
   // Next-cycle request, registered again by the top
   assign irq_pending = |(flags_d & enable);
endmodule
`default_nettype wire

// [design/dma_progress_top.sv]
/*
 File: APB register front end of one DMA channel: progress readback,
 interrupt enable, interrupt status and control.
 Assumes: APB master per the protocol; bus beat and error pulses come
 from the system bus master that performs the channel's transfers.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dma_progress_top
   import dma_progress_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] start_dest,
   input wire logic [15:0] start_count,
   input wire logic bus_beat_done,
   input wire logic bus_error,
   output logic irq,
   output logic busy
);
   beat_if bi ();
   logic [1:0] enable_q, enable_d;
   logic [31:0] rdata_q, rdata_d;
   logic ready_q, ready_d, err_q, err_d;
   logic irq_q, busy_q;
   logic start_pulse, soft_reset_pulse;
   logic [1:0] flags, clear_flags;
   logic irq_pending, engine_busy;
   logic setup, access, wr, rd;

   // --------------------------------------------------------------
   // APB decode: one wait-free access, answered in the access cycle
   // --------------------------------------------------------------
   // Read data is fetched at the setup edge; writes land only at the
   // access edge where the master samples pready high
   assign setup = psel && !penable;
   assign access = psel && penable && ready_q;
   assign wr = access && pwrite;
   assign rd = setup && !pwrite;

   // Decoded-address check, used by the error path only
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == control_offset) || (a == dest_addr_offset) || (a == remain_count_offset)
               || (a == irq_enable_offset) || (a == irq_status_offset);
   endfunction

   // Control strobes come from the low byte lane
   assign start_pulse = wr && paddr == control_offset && pstrb[0] && pwdata[start_bit];
   assign soft_reset_pulse = wr && paddr == control_offset && pstrb[0] && pwdata[soft_reset_bit];
   assign clear_flags = (wr && paddr == irq_status_offset && pstrb[0]) ?
                        pwdata[1:0] : 2'h0;

   // Next values for enable, read data and answer
   always_comb begin
      enable_d = enable_q;
      rdata_d = 32'h0000_0000;
      ready_d = setup;
      err_d = setup && !mapped(paddr);
      if (wr && paddr == irq_enable_offset && pstrb[0]) begin
         enable_d = pwdata[1:0];
      end
      if (rd) begin
         unique case (paddr)
            dest_addr_offset: rdata_d = bi.dest_addr;
            remain_count_offset: rdata_d = {16'h0000, bi.remain};
            irq_enable_offset: rdata_d = {30'h0, enable_q};
            irq_status_offset: rdata_d = {30'h0, flags};
            control_offset: rdata_d = {31'h0, engine_busy};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Register bus answer, enable and outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         enable_q <= irq_enable_reset;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         err_q <= 1'b0;
         irq_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         enable_q <= enable_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q <= err_d;
         irq_q <= irq_pending;
         busy_q <= engine_busy;
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = err_q;
   assign irq = irq_q;
   assign busy = busy_q;

   // --------------------------------------------------------------
   // Engine and interrupt flags
   // --------------------------------------------------------------
   dma_engine_core u_engine (
      .clk(clk),
      .resetn(resetn),
      .start(start_pulse),
      .soft_reset(soft_reset_pulse),
      .start_dest(start_dest),
      .start_count(start_count),
      .bus_beat_done(bus_beat_done),
      .bus_error(bus_error),
      .busy(engine_busy),
      .bi(bi.engine)
   );

   irq_status_core u_irq (
      .clk(clk),
      .resetn(resetn),
      .events({bi.done, bi.abort}),
      .clear(clear_flags),
      .enable(enable_q),
      .flags(flags),
      .irq_pending(irq_pending)
   );
endmodule
`default_nettype wire

// [tb/dma_progress_assertions.sv]
/* Checker on the top ports of the channel register block.
   Assumes: bound from the bench top; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module dma_progress_assertions
   import dma_progress_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic bus_error,
   input wire logic irq,
   input wire logic busy
);
   // ----
   // Setup detect and shadow of the enable bits
   // ----
   wire su = psel && !penable;
   wire wen = psel && penable && pready && pwrite && pstrb[0];
   logic [1:0] en_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) en_q <= irq_enable_reset;
      else if (wen && paddr == irq_enable_offset) en_q <= pwdata[1:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   access_latency_a: assert property (su |=> pready) else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
   unmapped_err_a: assert property (su && paddr == 8'h04 |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   ro_write_ok_a: assert property (su && pwrite && paddr == dest_addr_offset |=> pready && !pslverr)
      else $error("read-only write errored");
   count_upper_a: assert property (su && !pwrite && paddr == remain_count_offset |=> prdata[31:16] == 16'h0)
      else $error("count upper bits set");
   enable_upper_a: assert property (su && !pwrite && paddr == irq_enable_offset |=> prdata[31:2] == 30'h0)
      else $error("enable upper bits set");
   soft_reset_idle_a: assert property (wen && paddr == control_offset && pwdata[1] |-> ##2 !busy)
      else $error("busy after soft reset");
   abort_idles_a: assert property (busy && bus_error |-> ##[1:3] !busy) else $error("busy after error");
   irq_gated_a: assert property (en_q == 2'h0 && $past(en_q) == 2'h0 |-> !irq)
      else $error("irq with all enables off");
endmodule
`default_nettype wire

// [tb/bus_slave_model.sv]
/* Far-side model: system bus answering the channel's beats.
   Assumes: busy from the block; one beat pulse per gap while busy. */
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic busy,
   input wire logic slow,
   input wire logic fault,
   output logic beat,
   output logic error
);
   logic [2:0] wait_q, wait_d;
   // Pulse a beat, or an error response when faulting, then pause
   always_comb begin
      wait_d = wait_q;
      beat = 1'b0;
      error = 1'b0;
      if (busy && wait_q == 3'h0) begin
         beat = !fault;
         error = fault;
         wait_d = slow ? 3'h6 : 3'h3;
      end else if (wait_q != 3'h0) wait_d = wait_q - 3'h1;
   end
   // Gap counter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) wait_q <= 3'h0;
      else wait_q <= wait_d;
   end
endmodule
`default_nettype wire

// [tb/tb_dma_progress_top.sv]
/* Bench for the channel register block with a bus-side model.
   Assumes: APB master tasks; the package is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_dma_progress_top
   import dma_progress_pkg::*;
;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, fault = 0, ev;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, start_dest = 32'h0, rdv, prdata;
   logic [15:0] start_count = 16'h0;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, irq, busy, beat, error;
   int err_total = 0, checks = 0;
   dma_progress_top i_dma_progress_top (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .start_dest(start_dest), .start_count(start_count), .bus_beat_done(beat),
      .bus_error(error), .irq(irq), .busy(busy));
   bus_slave_model i_bus_slave_model (.clk(clk), .resetn(resetn), .busy(busy), .slow(slow),
      .fault(fault), .beat(beat), .error(error));
   // ----
   // Clock and helpers
   // ----
   initial begin
      forever #50 clk = ~clk;
   end
   task print_verdict;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One APB transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin err_total++; print_verdict; end
      else begin rdv = prdata; ev = pslverr; psel <= 1'b0; penable <= 1'b0; end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, e, rdv);
   endtask
   task wait_idle;
      int k;
      idle(2);
      k = 0;
      while (busy !== 1'b0 && k < 200) begin @(posedge clk); k++; end
      if (busy !== 1'b0) begin err_total++; print_verdict; end
      else idle(4);
   endtask
   // ----
   // Scenarios
   // ----
   task s_reset;
      rc(dest_addr_offset, 32'h0, "dest");
      rc(remain_count_offset, 32'h0, "count");
      rc(irq_enable_offset, 32'h1, "enable");
      chk("irq", 32'h0, irq);
   endtask
   task s_regs;
      wr(irq_enable_offset, 32'hffff_ffff);
      rc(irq_enable_offset, 32'h3, "enable rw");
      wr(dest_addr_offset, 32'h55);
      chk("ro err", 32'h0, ev);
      rc(dest_addr_offset, 32'h0, "dest ro");
      rc(8'h04, 32'h0, "unmapped");
      chk("unmapped err", 32'h1, ev);
   endtask
   task s_xfer(input logic [1:0] ie, input logic sl);
      wr(irq_enable_offset, {30'h0, ie});
      slow <= sl; start_dest <= 32'h1000; start_count <= 16'hc;
      wr(control_offset, 32'h1);
      wait_idle;
      rc(dest_addr_offset, 32'h1008, "dest");
      rc(remain_count_offset, 32'h0, "count");
      rc(irq_status_offset, 32'h2, "done flag");
      chk("done irq", {31'h0, ie[1]}, irq);
      wr(irq_status_offset, 32'h2); idle(2);
      rc(irq_status_offset, 32'h0, "done clear");
      chk("irq clear", 32'h0, irq);
   endtask
   task s_abort;
      wr(irq_enable_offset, 32'h0);
      fault <= 1'b1; start_count <= 16'h10;
      wr(control_offset, 32'h1);
      wait_idle; fault <= 1'b0;
      rc(irq_status_offset, 32'h1, "abort flag");
      chk("abort masked", 32'h0, irq);
      wr(irq_enable_offset, 32'h1); idle(2);
      chk("abort irq", 32'h1, irq);
      wr(irq_status_offset, 32'h1); idle(2);
      chk("abort clear", 32'h0, irq);
   endtask
   task s_soft;
      slow <= 1'b1; start_count <= 16'h20;
      wr(control_offset, 32'h1); idle(8);
      chk("running", 32'h1, busy);
      wr(control_offset, 32'h2); idle(2);
      chk("idle", 32'h0, busy);
      rc(remain_count_offset, 32'h0, "count cleared");
   endtask
   // Main sequence
   initial begin
      idle(4);
      resetn <= 1'b1;
      s_reset;
      s_regs;
      s_xfer(2'h2, 1'b0);
      s_xfer(2'h0, 1'b1);
      s_abort;
      s_soft;
      print_verdict;
   end
endmodule
bind dma_progress_top dma_progress_assertions i_dma_progress_assertions (.clk(clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_error(bus_error), .irq(irq), .busy(busy));
`default_nettype wire
